/* pkg/cstx_pkg.sv */
// Constants for the CSI-2 transmit map, sync and deskew register bank
package cstx_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_DEST_G1    = 16'h042e;
   localparam logic [15:0] OFS_DEST_G2    = 16'h042f;
   localparam logic [15:0] OFS_DEST_G3    = 16'h0430;
   localparam logic [15:0] OFS_CONCAT     = 16'h0431;
   localparam logic [15:0] OFS_MEMMAP     = 16'h0433;
   localparam logic [15:0] OFS_CNT_MODE   = 16'h0441;
   localparam logic [15:0] OFS_STATUS     = 16'h0442;
   localparam logic [15:0] OFS_DSK_INIT   = 16'h0443;
   localparam logic [15:0] OFS_DSK_PER    = 16'h0444;
   localparam logic [15:0] OFS_HS_PRE     = 16'h0445;
   localparam logic [15:0] OFS_HS_POST    = 16'h0446;
   // ----------------------------------------------------------------
   // Reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_HS_PRE     = 8'h71;
   localparam logic [7:0]  RST_HS_POST    = 8'h19;
   localparam logic [7:0]  MSK_CONCAT     = 8'hbf;
   localparam logic [7:0]  MSK_MEMMAP     = 8'h1f;
   localparam logic [7:0]  MSK_CNT_MODE   = 8'h01;
   localparam logic [7:0]  MSK_DSK_INIT   = 8'hb7;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_GEOM_WIDE  = 7;
   localparam int BIT_MAP12      = 0;
   localparam int BIT_MAP8       = 1;
   localparam int BIT_MAP10      = 2;
   localparam int BIT_UDP_PACK   = 3;
   localparam int BIT_MAP8_ALT2  = 4;
   localparam int BIT_CNT_EN     = 0;
   localparam int BIT_INIT_AUTO  = 7;
   localparam int BIT_INIT_TRIG  = 5;
   localparam int BIT_INIT_MAN   = 4;
   localparam int BIT_PER_EN     = 7;
   localparam int BIT_PER_FALL   = 6;
   // ----------------------------------------------------------------
   // Burst units in UI and entry count
   // ----------------------------------------------------------------
   // Nineteen bits: eight units of 32k UI reach exactly 2^18
   localparam logic [18:0] INIT_UNIT_UI   = 19'h0_8000;
   localparam logic [13:0] PER_UNIT_UI    = 14'h03e8;
   localparam int          N_ENTRY        = 12;
   localparam int          FIRST_ENTRY    = 4;

   typedef enum logic [1:0] {
      HS_IDLE,
      HS_PRE,
      HS_DATA,
      HS_POST
   } cstx_hs_t;
endpackage

/* rtl/cstx_regs.sv */
// CSI-2 transmit map, concatenation, sync status and deskew register bank
`timescale 1ns/1ps
module cstx_regs (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic [15:0]         reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   input  wire logic                sync_mode_en,
   input  wire logic                video_in_sync,
   input  wire logic                sync_lost_evt,
   input  wire logic                byte_clk,
   input  wire logic                vsync,
   input  wire logic                hs_tx_req,
   input  wire logic                pkt_valid,
   input  wire logic [7:0]          pkt_vc_dt,
   input  wire logic [1:0]          pkt_default_phy,
   input  wire logic [95:0]         entry_match_source,
   input  wire logic [11:0]         entry_enable,
   output logic      [23:0]         entry_phy_target,
   output logic      [1:0]          pkt_phy_sel,
   output logic                     pkt_phy_valid,
   output logic      [3:0]          line_concat_select,
   output logic      [1:0]          concat_master,
   output logic                     wide_concat_geometry,
   output logic                     alt_pixel_layout_twelve,
   output logic                     alt_pixel_layout_byte,
   output logic                     alt_pixel_layout_ten,
   output logic                     second_alt_pixel_layout_byte,
   output logic                     udp_triple_byte_packing,
   output logic                     vs_counter_en,
   output logic                     init_deskew_auto,
   output logic                     init_deskew_start,
   output logic      [18:0]         init_deskew_ui,
   output logic                     per_deskew_start,
   output logic      [13:0]         per_deskew_ui,
   output logic                     hs_data_en,
   output logic                     clk_lane_active
);
   import cstx_pkg::*;

   // ----------------------------------------------------------------
   // Register storage and write decode
   // ----------------------------------------------------------------
   logic [7:0] dest_r [3];
   logic [7:0] concat_r, memmap_r, cnt_mode_r, dsk_init_r, dsk_per_r;
   logic [7:0] hs_pre_r, hs_post_r, rdata_r;
   logic       lost_r, dsk_trig_r;
   logic [18:0] init_ui_r;
   logic [13:0] per_ui_r;

   wire wr_g1    = reg_wr && (reg_addr == OFS_DEST_G1);
   wire wr_g2    = reg_wr && (reg_addr == OFS_DEST_G2);
   wire wr_g3    = reg_wr && (reg_addr == OFS_DEST_G3);
   wire wr_cat   = reg_wr && (reg_addr == OFS_CONCAT);
   wire wr_mm    = reg_wr && (reg_addr == OFS_MEMMAP);
   wire wr_cm    = reg_wr && (reg_addr == OFS_CNT_MODE);
   wire wr_di    = reg_wr && (reg_addr == OFS_DSK_INIT);
   wire wr_dp    = reg_wr && (reg_addr == OFS_DSK_PER);
   wire wr_pre   = reg_wr && (reg_addr == OFS_HS_PRE);
   wire wr_post  = reg_wr && (reg_addr == OFS_HS_POST);
   wire rd_stat  = reg_rd && (reg_addr == OFS_STATUS);

   // Manual deskew fires on a change of the trigger bit, either way, written with the manual bit set
   wire man_fire = wr_di && reg_wdata[BIT_INIT_MAN] &&
                   (reg_wdata[BIT_INIT_TRIG] !=
                    dsk_init_r[BIT_INIT_TRIG]);

   // Plain write-only-when-addressed registers; masks keep reserved 0
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dest_r[0]  <= RST_ZERO;
         dest_r[1]  <= RST_ZERO;
         dest_r[2]  <= RST_ZERO;
         concat_r   <= RST_ZERO;
         memmap_r   <= RST_ZERO;
         cnt_mode_r <= RST_ZERO;
         dsk_init_r <= RST_ZERO;
         dsk_per_r  <= RST_ZERO;
         hs_pre_r   <= RST_HS_PRE;
         hs_post_r  <= RST_HS_POST;
      end else begin
         if (wr_g1) dest_r[0] <= reg_wdata;
         if (wr_g2) dest_r[1] <= reg_wdata;
         if (wr_g3) dest_r[2] <= reg_wdata;
         if (wr_cat) concat_r <= reg_wdata & MSK_CONCAT;
         if (wr_mm) memmap_r <= reg_wdata & MSK_MEMMAP;
         if (wr_cm) cnt_mode_r <= reg_wdata & MSK_CNT_MODE;
         if (wr_di) dsk_init_r <= reg_wdata & MSK_DSK_INIT;
         if (wr_dp) dsk_per_r <= reg_wdata;
         if (wr_pre) hs_pre_r <= reg_wdata;
         if (wr_post) hs_post_r <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Status, read port and deskew burst lengths
   // ----------------------------------------------------------------
   wire [7:0] status_w = {5'b0_0000, lost_r, video_in_sync,
                          sync_mode_en};
   wire [7:0] rd_mux =
      (reg_addr == OFS_DEST_G1)  ? dest_r[0]  :
      (reg_addr == OFS_DEST_G2)  ? dest_r[1]  :
      (reg_addr == OFS_DEST_G3)  ? dest_r[2]  :
      (reg_addr == OFS_CONCAT)   ? concat_r   :
      (reg_addr == OFS_MEMMAP)   ? memmap_r   :
      (reg_addr == OFS_CNT_MODE) ? cnt_mode_r :
      (reg_addr == OFS_STATUS)   ? status_w   :
      (reg_addr == OFS_DSK_INIT) ? dsk_init_r :
      (reg_addr == OFS_DSK_PER)  ? dsk_per_r  :
      (reg_addr == OFS_HS_PRE)   ? hs_pre_r   :
      (reg_addr == OFS_HS_POST)  ? hs_post_r  : RST_ZERO;
   wire [18:0] init_ui_nxt = 19'({16'b0, dsk_init_r[2:0]} + 19'd1)
                             * INIT_UNIT_UI;
   wire [13:0] per_ui_nxt  = 14'({11'b0, dsk_per_r[2:0]} + 14'd1)
                             * PER_UNIT_UI;

   // A loss event in the read cycle survives so no loss goes unseen
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lost_r     <= 1'b0;
         rdata_r    <= RST_ZERO;
         dsk_trig_r <= 1'b0;
         init_ui_r  <= INIT_UNIT_UI;
         per_ui_r   <= PER_UNIT_UI;
      end else begin
         lost_r     <= sync_lost_evt | (lost_r & ~rd_stat);
         if (reg_rd) rdata_r <= rd_mux;
         dsk_trig_r <= man_fire;
         init_ui_r  <= init_ui_nxt;
         per_ui_r   <= per_ui_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers for byte clock and vsync
   // ----------------------------------------------------------------
   logic [2:0] bclk_s_r, vs_s_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bclk_s_r <= 3'b000;
         vs_s_r   <= 3'b000;
      end else begin
         bclk_s_r <= {bclk_s_r[1:0], byte_clk};
         vs_s_r   <= {vs_s_r[1:0], vsync};
      end
   end
   // Edges are taken from stages two and three, never from stage one
   wire bclk_edge = bclk_s_r[1] & ~bclk_s_r[2];
   wire vs_rise   = vs_s_r[1] & ~vs_s_r[2];
   wire vs_fall   = ~vs_s_r[1] & vs_s_r[2];

   // ----------------------------------------------------------------
   // Periodic deskew frame divider
   // ----------------------------------------------------------------
   logic [6:0] fcnt_r;
   logic       per_start_r;
   wire        vs_sel   = dsk_per_r[BIT_PER_FALL] ? vs_fall
                                                   : vs_rise;
   wire [6:0]  fmask    = 7'((8'd1 << dsk_per_r[5:3]) - 8'd1);
   wire        per_hit  = dsk_per_r[BIT_PER_EN] && vs_sel &&
                          (fcnt_r >= fmask);

   // Counter rests at zero while disabled so the first frame counts
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fcnt_r      <= 7'd0;
         per_start_r <= 1'b0;
      end else begin
         per_start_r <= per_hit;
         if (!dsk_per_r[BIT_PER_EN] || per_hit) fcnt_r <= 7'd0;
         else if (vs_sel) fcnt_r <= fcnt_r + 7'd1;
      end
   end

   // ----------------------------------------------------------------
   // HS entry and exit sequencing in byte clocks
   // ----------------------------------------------------------------
   cstx_hs_t   st_r, st_nxt;
   logic [7:0] hcnt_r, hcnt_nxt;
   logic       hs_en_r, clk_act_r;

   // Counts start at zero on entry; a zero count passes at once
   always_comb begin
      st_nxt   = st_r;
      hcnt_nxt = hcnt_r;
      case (st_r)
         HS_IDLE: begin
            hcnt_nxt = 8'd0;
            if (hs_tx_req) st_nxt = HS_PRE;
         end
         HS_PRE: begin
            if (hcnt_r == hs_pre_r) begin
               st_nxt   = HS_DATA;
               hcnt_nxt = 8'd0;
            end else if (bclk_edge) begin
               hcnt_nxt = hcnt_r + 8'd1;
            end
         end
         HS_DATA: begin
            hcnt_nxt = 8'd0;
            if (!hs_tx_req) st_nxt = HS_POST;
         end
         default: begin
            if (hcnt_r == hs_post_r) begin
               st_nxt   = HS_IDLE;
               hcnt_nxt = 8'd0;
            end else if (bclk_edge) begin
               hcnt_nxt = hcnt_r + 8'd1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r      <= HS_IDLE;
         hcnt_r    <= 8'd0;
         hs_en_r   <= 1'b0;
         clk_act_r <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         hcnt_r    <= hcnt_nxt;
         hs_en_r   <= (st_nxt == HS_DATA);
         clk_act_r <= (st_nxt != HS_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Packet steering over entries four to fifteen
   // ----------------------------------------------------------------
   logic [11:0] hit_w;
   genvar gi;
   generate
      for (gi = 0; gi < N_ENTRY; gi++) begin : g_match
         // Channel in [7:6], type in [5:0]; both must agree
         assign hit_w[gi] = entry_enable[gi] &&
            (entry_match_source[gi*8+7 -: 2] == pkt_vc_dt[7:6]) &&
            (entry_match_source[gi*8+5 -: 6] == pkt_vc_dt[5:0]);
      end
   endgenerate

   // Lowest matching entry wins; overlap is a software fault
   logic [1:0] route_w;
   always_comb begin
      route_w = pkt_default_phy;
      for (int i = N_ENTRY - 1; i >= 0; i--) begin
         if (hit_w[i]) route_w = dest_r[i/4][(i%4)*2 +: 2];
      end
   end

   logic [1:0] phy_sel_r;
   logic       phy_vld_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phy_sel_r <= 2'b00;
         phy_vld_r <= 1'b0;
      end else begin
         phy_vld_r <= pkt_valid;
         if (pkt_valid) phy_sel_r <= route_w;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all taken from flops
   // ----------------------------------------------------------------
   assign reg_rdata                    = rdata_r;
   assign entry_phy_target             = {dest_r[2], dest_r[1],
                                          dest_r[0]};
   assign pkt_phy_sel                  = phy_sel_r;
   assign pkt_phy_valid                = phy_vld_r;
   assign line_concat_select           = concat_r[3:0];
   assign concat_master                = concat_r[5:4];
   assign wide_concat_geometry         = concat_r[BIT_GEOM_WIDE];
   assign alt_pixel_layout_twelve      = memmap_r[BIT_MAP12];
   assign alt_pixel_layout_byte        = memmap_r[BIT_MAP8];
   assign alt_pixel_layout_ten         = memmap_r[BIT_MAP10];
   assign second_alt_pixel_layout_byte = memmap_r[BIT_MAP8_ALT2];
   assign udp_triple_byte_packing      = memmap_r[BIT_UDP_PACK];
   assign vs_counter_en                = cnt_mode_r[BIT_CNT_EN];
   assign init_deskew_auto             = dsk_init_r[BIT_INIT_AUTO];
   assign init_deskew_start            = dsk_trig_r;
   assign init_deskew_ui               = init_ui_r;
   assign per_deskew_start             = per_start_r;
   assign per_deskew_ui                = per_ui_r;
   assign hs_data_en                   = hs_en_r;
   assign clk_lane_active              = clk_act_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_stat_rd_quiet;
      rd_stat && !sync_lost_evt;
   endsequence
   sequence s_man_toggle;
      man_fire;
   endsequence

   property p_loss_clear;
      @(posedge clk_sys) disable iff (!nrst)
      s_stat_rd_quiet |=> !status_w[2];
   endproperty
   a_loss_clear: assert property (p_loss_clear)
      else $error("loss flag not cleared by status read");

   property p_loss_set_wins;
      @(posedge clk_sys) disable iff (!nrst)
      sync_lost_evt |=> status_w[2];
   endproperty
   a_loss_set_wins: assert property (p_loss_set_wins)
      else $error("loss event dropped");

   property p_man_once;
      @(posedge clk_sys) disable iff (!nrst)
      s_man_toggle |=> init_deskew_start ##1
                       (!init_deskew_start || $past(man_fire, 1));
   endproperty
   a_man_once: assert property (p_man_once)
      else $error("manual deskew pulse wrong");

   property p_man_needs_sel;
      @(posedge clk_sys) disable iff (!nrst)
      (wr_di && !reg_wdata[BIT_INIT_MAN]) |=> !init_deskew_start;
   endproperty
   a_man_needs_sel: assert property (p_man_needs_sel)
      else $error("manual deskew fired while not selected");

   property p_init_len;
      @(posedge clk_sys) disable iff (!nrst)
      $stable(dsk_init_r[2:0]) ##1 $stable(dsk_init_r[2:0]) |->
         init_deskew_ui == 19'(({16'b0, dsk_init_r[2:0]} + 19'd1)
                               << 15);
   endproperty
   a_init_len: assert property (p_init_len)
      else $error("initial deskew length mismatch");

   property p_pre_wait;
      @(posedge clk_sys) disable iff (!nrst)
      $rose(hs_data_en) |-> $past(hcnt_r, 1) == hs_pre_r
                            && $past(st_r, 1) == HS_PRE;
   endproperty
   a_pre_wait: assert property (p_pre_wait)
      else $error("HS data started before pre count");

   property p_post_hold;
      @(posedge clk_sys) disable iff (!nrst)
      $fell(clk_lane_active) |-> $past(hcnt_r, 1) == hs_post_r;
   endproperty
   a_post_hold: assert property (p_post_hold)
      else $error("clock lane stopped before post count");

   property p_data_has_clk;
      @(posedge clk_sys) disable iff (!nrst)
      hs_data_en |-> clk_lane_active;
   endproperty
   a_data_has_clk: assert property (p_data_has_clk)
      else $error("HS data without clock lane");

   property p_rsvd_zero;
      @(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == OFS_MEMMAP |=>
         reg_rdata[7:5] == 3'b000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved bits read nonzero");

   property p_unmatched;
      @(posedge clk_sys) disable iff (!nrst)
      (pkt_valid && hit_w == 12'h000) |=>
         pkt_phy_valid && pkt_phy_sel == $past(pkt_default_phy);
   endproperty
   a_unmatched: assert property (p_unmatched)
      else $error("unmatched packet rerouted");

   property p_per_off;
      @(posedge clk_sys) disable iff (!nrst)
      !dsk_per_r[BIT_PER_EN] ##1 !dsk_per_r[BIT_PER_EN] |->
         !per_deskew_start;
   endproperty
   a_per_off: assert property (p_per_off)
      else $error("periodic deskew while disabled");
endmodule

/* bench/cstx_far_model.sv */
// Far-side byte clock and frame-sync source for the register bank
`timescale 1ns/1ps
module cstx_far_model (
   input  wire logic byte_run,
   input  wire logic vs_lvl,
   output logic      byte_clk,
   output logic      vsync
);
   // Byte clock rests low between transfers, so no edge leaks into counts
   initial byte_clk = 1'b0;
   always begin
      #80;
      byte_clk = byte_run ? ~byte_clk : 1'b0;
   end
   // Frame sync follows the bench level as a pin would
   assign vsync = vs_lvl;
endmodule

/* bench/cstx_regs_tb_top.sv */
// Self-checking bench for the CSI-2 transmit register bank
`timescale 1ns/1ps
module cstx_regs_tb_top;
   import cstx_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, pkt_vc_dt = 8'h00, reg_rdata;
   logic        sync_mode_en = 1'b0, video_in_sync = 1'b0;
   logic        sync_lost_evt = 1'b0, hs_tx_req = 1'b0, pkt_valid = 1'b0;
   logic        byte_run = 1'b0, vs_lvl = 1'b0, byte_clk, vsync;
   logic [1:0]  pkt_default_phy = 2'h0, pkt_phy_sel, concat_master;
   logic [95:0] entry_match_source = '0;
   logic [11:0] entry_enable = 12'h000;
   logic [23:0] entry_phy_target;
   logic [3:0]  line_concat_select;
   logic [18:0] init_deskew_ui;
   logic [13:0] per_deskew_ui;
   logic        pkt_phy_valid, wide_concat_geometry, alt_pixel_layout_twelve;
   logic        alt_pixel_layout_byte, alt_pixel_layout_ten;
   logic        second_alt_pixel_layout_byte, udp_triple_byte_packing;
   logic        vs_counter_en, init_deskew_auto, init_deskew_start;
   logic        per_deskew_start, hs_data_en, clk_lane_active;
   int          mismatches = 0, compares = 0, n_init = 0, n_per = 0;
   int          n_byte = 0, b0, n0;
   // Register table in offset order: reset values and readable masks
   logic [15:0] ofs [11] = '{OFS_DEST_G1, OFS_DEST_G2, OFS_DEST_G3,
      OFS_CONCAT, OFS_MEMMAP, OFS_CNT_MODE, OFS_STATUS, OFS_DSK_INIT,
      OFS_DSK_PER, OFS_HS_PRE, OFS_HS_POST};
   logic [7:0]  rstv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h71, 8'h19};
   logic [7:0]  msk [11] = '{8'hff, 8'hff, 8'hff, 8'hbf, 8'h1f, 8'h01,
      8'h00, 8'hb7, 8'hff, 8'hff, 8'hff};
   logic [7:0]  pcfg [3] = '{8'h8a, 8'hc0, 8'h08};
   logic [13:0] pui [3] = '{14'h0bb8, 14'h03e8, 14'h03e8};
   int          pexp [3] = '{2, 4, 0};

   cstx_regs uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .sync_mode_en, .video_in_sync, .sync_lost_evt, .byte_clk,
      .vsync, .hs_tx_req, .pkt_valid, .pkt_vc_dt, .pkt_default_phy,
      .entry_match_source, .entry_enable, .entry_phy_target, .pkt_phy_sel,
      .pkt_phy_valid, .line_concat_select, .concat_master,
      .wide_concat_geometry, .alt_pixel_layout_twelve, .alt_pixel_layout_byte,
      .alt_pixel_layout_ten, .second_alt_pixel_layout_byte,
      .udp_triple_byte_packing, .vs_counter_en, .init_deskew_auto,
      .init_deskew_start, .init_deskew_ui, .per_deskew_start, .per_deskew_ui,
      .hs_data_en, .clk_lane_active);
   cstx_far_model far (.byte_run, .vs_lvl, .byte_clk, .vsync);

   // ------------------------------------------------------------
   // Clock, pulse counters and shared tasks
   // ------------------------------------------------------------
   always #10 clk_sys = ~clk_sys;
   always @(posedge byte_clk) n_byte++;
   // Pulses are counted at the edge after launch, where they are settled
   always @(posedge clk_sys) begin
      if (init_deskew_start === 1'b1) n_init++;
      if (per_deskew_start === 1'b1) n_per++;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {24'h00_0000, reg_rdata}, {24'h00_0000, e});
   endtask
   task automatic send(input logic [7:0] vd, input logic [1:0] e);
      @(posedge clk_sys);
      pkt_vc_dt <= vd;
      pkt_valid <= 1'b1;
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      #1;
      chk("pkt_phy_valid", {31'h0, pkt_phy_valid}, 32'h1);
      chk("pkt_phy_sel", {30'h0, pkt_phy_sel}, {30'h0, e});
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 0; i < 11; i++) rd(ofs[i], rstv[i]);
      wr(16'h0432, 8'hff);
      for (int i = 0; i < 11; i++) wr(ofs[i], 8'hff);
      for (int i = 0; i < 11; i++) rd(ofs[i], msk[i]);
      rd(16'h0432, 8'h00);
      chk("concat", {wide_concat_geometry, concat_master,
         line_concat_select}, 32'h7f);
      wr(OFS_CONCAT, 8'h25);
      chk("concat", {wide_concat_geometry, concat_master,
         line_concat_select}, 32'h25);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_MEMMAP, 8'h01 << i);
         chk("memmap", {second_alt_pixel_layout_byte, udp_triple_byte_packing,
            alt_pixel_layout_ten, alt_pixel_layout_byte,
            alt_pixel_layout_twelve}, 32'h1 << i);
      end
      chk("counter", {31'h0, vs_counter_en}, 32'h1);
      wr(OFS_CNT_MODE, 8'hfe);
      chk("counter", {31'h0, vs_counter_en}, 32'h0);
      $display("register test done");
      // Sticky loss flag survives until the first status read
      @(posedge clk_sys);
      sync_mode_en <= 1'b1;
      video_in_sync <= 1'b1;
      sync_lost_evt <= 1'b1;
      @(posedge clk_sys);
      sync_lost_evt <= 1'b0;
      rd(OFS_STATUS, 8'h07);
      video_in_sync <= 1'b0;
      rd(OFS_STATUS, 8'h01);
      wr(OFS_STATUS, 8'hff);
      rd(OFS_STATUS, 8'h01);
      $display("status test done");
      // Entry 5 and 9 share a match; the lower entry must win
      entry_match_source[15:8] <= 8'h6b;
      entry_match_source[47:40] <= 8'h6b;
      entry_match_source[95:88] <= 8'hab;
      entry_enable <= 12'h822;
      pkt_default_phy <= 2'h2;
      for (int k = 0; k < 4; k++) begin
         wr(OFS_DEST_G1, 8'(k << 2));
         wr(OFS_DEST_G2, 8'((3 - k) << 2));
         wr(OFS_DEST_G3, 8'(k << 6));
         chk("targets", {8'h00, entry_phy_target}, {8'h00, 8'(k << 6),
            8'((3 - k) << 2), 8'(k << 2)});
         send(8'h6b, 2'(k));
         send(8'hab, 2'(k));
      end
      send(8'h2b, 2'h2);
      $display("routing test done");
      n0 = n_init;
      wr(OFS_DSK_INIT, 8'h93);
      chk("init_start", {31'h0, init_deskew_start}, 32'h1);
      @(posedge clk_sys);
      #1;
      chk("init_ui", {13'h0, init_deskew_ui}, 32'h2_0000);
      chk("init_auto", {31'h0, init_deskew_auto}, 32'h1);
      wr(OFS_DSK_INIT, 8'h93);
      wr(OFS_DSK_INIT, 8'h27);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("init_ui", {13'h0, init_deskew_ui}, 32'h4_0000);
      chk("init_auto", {31'h0, init_deskew_auto}, 32'h0);
      chk("init_pulses", n_init - n0, 32'h1);
      $display("initial deskew test done");
      wr(OFS_HS_PRE, 8'h03);
      wr(OFS_HS_POST, 8'h02);
      hs_tx_req <= 1'b1;
      byte_run <= 1'b1;
      b0 = n_byte;
      for (int t = 0; t < 200 && hs_data_en !== 1'b1; t++) @(posedge clk_sys);
      chk("pre_edges", {31'h0, (n_byte - b0) inside {[3:4]}}, 32'h1);
      chk("clk_lane", {31'h0, clk_lane_active}, 32'h1);
      hs_tx_req <= 1'b0;
      b0 = n_byte;
      for (int t = 0; t < 200 && clk_lane_active !== 1'b0; t++)
         @(posedge clk_sys);
      chk("post_edges", {31'h0, (n_byte - b0) inside {[2:3]}}, 32'h1);
      byte_run <= 1'b0;
      $display("hs timing test done");
      // A trailing extra rising edge tells rise and fall triggers apart
      for (int j = 0; j < 3; j++) begin
         wr(OFS_DSK_PER, 8'h00);
         wr(OFS_DSK_PER, pcfg[j]);
         n0 = n_per;
         for (int p = 0; p < 5; p++) begin
            vs_lvl <= 1'b1;
            repeat (10) @(posedge clk_sys);
            if (p < 4) vs_lvl <= 1'b0;
            repeat (10) @(posedge clk_sys);
         end
         chk("per_pulses", n_per - n0, pexp[j]);
         chk("per_ui", {18'h0, per_deskew_ui}, {18'h0, pui[j]});
         vs_lvl <= 1'b0;
         repeat (10) @(posedge clk_sys);
      end
      $display("periodic deskew test done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(OFS_HS_PRE, 8'h71);
      $display("second reset test done");
      stop_test();
   end
   // Watchdog well beyond the expected run of under a thousand cycles
   initial begin
      #1_000_000;
      mismatches++;
      stop_test();
   end
endmodule
